// *** rtl/smms_sequencer.sv ***
/*
 * management-mode sequencer: takes the management interrupt, drains,
 * saves context, signals entry, restores on resume, checks and exits or
 * shuts down. registers over classic wishbone.
 * assumes synchronous core inputs and a memory port that answers with ack.
 */
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "smms_defs.svh"

// Notes on behaviour
// - management interrupt in real, protected or v86 mode always enters the mode.
// - resume returns to the operating mode saved at entry.
// - take only at boundary, wait retire and store drain, save, enter, start.
// - signal entry by acknowledge transaction or active-low mode-active pin.
// - transaction variant marks every bus transaction while in the mode.
// - coinciding nmi, maskable interrupt or debug exception are held off.
// - in the mode latch only one new request, serve it after resume.
// - resume outside the mode raises an invalid-opcode fault.
// - resume reloads state from the saved image, then returns control.
// - after resume signal exit by acknowledge transaction or releasing pin.
// - invalid saved state enters shutdown and issues a shutdown bus cycle.
// - restored control register four with any reserved bit set is invalid.
// - paging without protection, or not-write-through without cache-disable, is invalid.
// - optionally, base not aligned to 32 kbytes is invalid.
// - shutdown halts until reset, init or nmi.
// - shutdown optionally inhibits maskable interrupts and address-bit-20 mask.
// - base resets to 30000h.
// - first handler fetch at base plus 8000h.
// - state is saved between base plus fe00h and base plus ffffh.
// - management ram is taken as 64 kbytes at the base.
// - a request may wait one instruction after interrupt-enable or stack load.
module smms_sequencer (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core side
  input wire logic mgmt_interrupt_n_i,
  input wire logic boundary_i,
  input wire logic int_hold_i,
  input wire logic retired_i,
  input wire logic stores_done_i,
  input wire logic resume_from_mgmt_i,
  input wire logic nmi_i,
  input wire logic init_i,
  input wire logic [1:0] cur_mode_i,
  input wire logic [31:0] control_reg_zero_i,
  input wire logic [31:0] control_reg_four_i,
  output logic drain_req_o,
  output logic int_block_o,
  output logic handler_fetch_o,
  output logic [31:0] handler_addr_o,
  output logic invalid_opcode_fault_o,
  output logic resume_done_o,
  output logic [1:0] restored_mode_o,
  output logic [31:0] restored_control_reg_zero_o,
  output logic [31:0] restored_control_reg_four_o,
  // management ram port
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  // system signalling
  output logic mgmt_active_n_o,
  output logic mgmt_ack_transaction_o,
  output logic ext_status_four_o,
  output logic shutdown_o,
  output logic shutdown_cycle_o,
  output logic inhibit_maskable_int_req_o,
  output logic inhibit_addr_bit20_mask_o
);
  import smms_pkg::*;

  // ==========================================================
  // state
  smms_state_t state;
  smms_state_t next_state;
  smms_ctrl_t ctrl;
  logic [31:0] mgmt_ram_base;
  logic [2:0] idx;
  logic [2:0] next_idx;
  logic pend;
  logic next_pend;
  logic req_prev;
  logic req_fall;
  logic in_mode;
  logic [31:0] img_reg_zero;
  logic [31:0] img_reg_four;
  logic [1:0] sv_mode;
  logic [31:0] sv_base;
  logic bad_state;
  logic word_done;

  function automatic logic [31:0] save_addr(input logic [31:0] base, input logic [2:0] i);
    save_addr = base + `SMMS_SAVE_LO + {27'h0, i, 2'h0};
  endfunction

  assign req_fall = req_prev & ~mgmt_interrupt_n_i;
  assign word_done = mem_req_o & mem_ack_i;

  // invalid image checks
  always_comb begin
    bad_state = 1'b0;
    if ((img_reg_four & `SMMS_CTRL_FOUR_RSVD) != 32'h0000_0000) begin
      bad_state = 1'b1;
    end
    if (img_reg_zero[`SMMS_PAGING_BIT] & ~img_reg_zero[`SMMS_PROTECT_BIT]) begin
      bad_state = 1'b1;
    end
    if (img_reg_zero[`SMMS_NO_WT_BIT] & ~img_reg_zero[`SMMS_CACHE_OFF_BIT]) begin
      bad_state = 1'b1;
    end
    if (ctrl.align_chk_en && ((sv_base & `SMMS_ALIGN_MASK) != 32'h0000_0000)) begin
      bad_state = 1'b1;
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    next_state = state;
    next_idx = idx;
    case (state)
      ST_IDLE: begin
        if (pend && boundary_i && !int_hold_i) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (retired_i && stores_done_i) begin
          next_state = ST_SAVE;
          next_idx = 3'h0;
        end
      end
      ST_SAVE: begin
        if (word_done) begin
          next_idx = idx + 3'h1;
          if (idx == `SMMS_SAVE_WORDS - 3'h1) begin
            next_state = ST_ENTER;
          end
        end
      end
      ST_ENTER: next_state = ST_FETCH;
      ST_FETCH: next_state = ST_INMODE;
      ST_INMODE: begin
        if (resume_from_mgmt_i) begin
          next_state = ST_RESTORE;
          next_idx = 3'h0;
        end
      end
      ST_RESTORE: begin
        if (word_done) begin
          next_idx = idx + 3'h1;
          if (idx == `SMMS_SAVE_WORDS - 3'h1) begin
            next_state = ST_CHECK;
          end
        end
      end
      ST_CHECK: next_state = bad_state ? ST_SHUTDN : ST_EXIT;
      ST_EXIT: next_state = ST_IDLE;
      ST_SHUTDN: begin
        if (init_i || nmi_i) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      idx <= 3'h0;
    end else begin
      state <= next_state;
      idx <= next_idx;
    end
  end

  // ==========================================================
  // pending request latch, new edge wins over the clear at entry
  always_comb begin
    next_pend = pend;
    if (state == ST_IDLE && next_state == ST_DRAIN) begin
      next_pend = 1'b0;
    end
    if (req_fall && state != ST_SHUTDN) begin
      next_pend = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend <= 1'b0;
      req_prev <= 1'b1;
      int_block_o <= 1'b0;
      drain_req_o <= 1'b0;
    end else begin
      pend <= next_pend;
      req_prev <= mgmt_interrupt_n_i;
      int_block_o <= next_pend | (next_state != ST_IDLE);
      drain_req_o <= (next_state == ST_DRAIN);
    end
  end

  // ==========================================================
  // management ram port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 32'h0000_0000;
      mem_wdata_o <= 32'h0000_0000;
    end else begin
      mem_req_o <= (next_state == ST_SAVE || next_state == ST_RESTORE) && !word_done;
      mem_we_o <= (next_state == ST_SAVE);
      if (!mem_req_o || word_done) begin
        mem_addr_o <= save_addr(mgmt_ram_base, next_idx);
        case (next_idx)
          3'h0: mem_wdata_o <= control_reg_zero_i;
          3'h1: mem_wdata_o <= control_reg_four_i;
          3'h2: mem_wdata_o <= {30'h0, cur_mode_i};
          default: mem_wdata_o <= mgmt_ram_base;
        endcase
      end
    end
  end

  // restored image
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      img_reg_zero <= 32'h0000_0000;
      img_reg_four <= 32'h0000_0000;
      sv_mode <= 2'h0;
      sv_base <= `SMMS_BASE_RST;
    end else if (state == ST_RESTORE && word_done) begin
      case (idx)
        3'h0: img_reg_zero <= mem_rdata_i;
        3'h1: img_reg_four <= mem_rdata_i;
        3'h2: sv_mode <= mem_rdata_i[1:0];
        default: sv_base <= mem_rdata_i;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mgmt_ram_base <= `SMMS_BASE_RST;
      resume_done_o <= 1'b0;
      restored_mode_o <= 2'h0;
      restored_control_reg_zero_o <= 32'h0000_0000;
      restored_control_reg_four_o <= 32'h0000_0000;
    end else begin
      resume_done_o <= (state == ST_CHECK) && !bad_state;
      if (state == ST_CHECK && !bad_state) begin
        restored_mode_o <= sv_mode;
        restored_control_reg_zero_o <= img_reg_zero;
        restored_control_reg_four_o <= img_reg_four;
        mgmt_ram_base <= sv_base;
      end
    end
  end

  // ==========================================================
  // entry, fetch and exit signalling
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_mode <= 1'b0;
      mgmt_active_n_o <= 1'b1;
      mgmt_ack_transaction_o <= 1'b0;
      ext_status_four_o <= 1'b0;
      handler_fetch_o <= 1'b0;
      handler_addr_o <= 32'h0000_0000;
      invalid_opcode_fault_o <= 1'b0;
    end else begin
      handler_fetch_o <= (state == ST_FETCH);
      handler_addr_o <= mgmt_ram_base + `SMMS_HANDLER_OFS;
      invalid_opcode_fault_o <= resume_from_mgmt_i && !in_mode;
      mgmt_ack_transaction_o <= ctrl.variant_txn &&
        (state == ST_ENTER || (state == ST_CHECK && !bad_state));
      if (state == ST_ENTER) begin
        in_mode <= 1'b1;
        mgmt_active_n_o <= ctrl.variant_txn;
        ext_status_four_o <= ctrl.variant_txn;
      end else if (state == ST_CHECK) begin
        in_mode <= 1'b0;
        mgmt_active_n_o <= 1'b1;
        ext_status_four_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // shutdown
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shutdown_o <= 1'b0;
      shutdown_cycle_o <= 1'b0;
      inhibit_maskable_int_req_o <= 1'b0;
      inhibit_addr_bit20_mask_o <= 1'b0;
    end else begin
      shutdown_cycle_o <= (state == ST_CHECK) && bad_state;
      shutdown_o <= (next_state == ST_SHUTDN);
      inhibit_maskable_int_req_o <= (next_state == ST_SHUTDN) && ctrl.shut_inhibit_en;
      inhibit_addr_bit20_mask_o <= (next_state == ST_SHUTDN) && ctrl.shut_inhibit_en;
    end
  end

  // ==========================================================
  // wishbone slave, one wait state, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl <= `SMMS_CTRL_RST;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
          wb_adr_i == `SMMS_OFS_CTRL) begin
        ctrl <= wb_dat_i[2:0];
      end
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        case (wb_adr_i)
          `SMMS_OFS_CTRL: wb_dat_o <= {29'h0, ctrl};
          `SMMS_OFS_STATUS: wb_dat_o <= {25'h0, state, shutdown_o, pend, in_mode};
          `SMMS_OFS_BASE: wb_dat_o <= mgmt_ram_base;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_save_after_drain: assert property (
    (state == ST_DRAIN && next_state == ST_SAVE) |-> retired_i && stores_done_i)
    else $error("save started before drain");
  a_take_at_boundary: assert property (
    $rose(drain_req_o) |-> $past(boundary_i && !int_hold_i && pend))
    else $error("request taken off a boundary");
  a_fetch_address: assert property (
    handler_fetch_o |-> handler_addr_o == mgmt_ram_base + `SMMS_HANDLER_OFS)
    else $error("bad handler fetch address");
  a_active_before_fetch: assert property (
    handler_fetch_o && !ctrl.variant_txn |-> !mgmt_active_n_o && $past(!mgmt_active_n_o))
    else $error("mode active not raised before fetch");
  a_save_window: assert property (
    mem_req_o |-> mem_addr_o >= mgmt_ram_base + `SMMS_SAVE_LO &&
      mem_addr_o <= mgmt_ram_base + `SMMS_SAVE_HI)
    else $error("save access outside save area");
  a_fault_outside: assert property (
    resume_from_mgmt_i && !in_mode |=> invalid_opcode_fault_o)
    else $error("resume outside mode not faulted");
  a_one_pending: assert property (
    in_mode && req_fall |=> pend && state != ST_DRAIN)
    else $error("request in mode lost or taken");
  a_bad_shutdown: assert property (
    state == ST_CHECK && bad_state |=> shutdown_o && shutdown_cycle_o ##1 !shutdown_cycle_o)
    else $error("bad image did not shut down");
  a_shutdown_hold: assert property (
    shutdown_o && !init_i && !nmi_i |=> shutdown_o)
    else $error("shutdown left without wake event");
  a_reset_base: assert property (
    $past(rst_i) |-> mgmt_ram_base == `SMMS_BASE_RST)
    else $error("base not reset");
  a_block_others: assert property (
    pend |-> int_block_o)
    else $error("other interrupts not held off");
  a_exit_signal: assert property (
    resume_done_o |-> mgmt_active_n_o && !ext_status_four_o && in_mode == 1'b0)
    else $error("exit not signalled");
  a_wb_ack: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack timing");

  c_entry: cover property (state == ST_SAVE ##[1:100] handler_fetch_o);
  c_resume: cover property (resume_done_o);
  c_shutdown: cover property (shutdown_cycle_o);
  c_pending: cover property (in_mode && req_fall ##[1:200] state == ST_DRAIN);
endmodule

// *** inc/smms_defs.svh ***
/*
 * constants of the management-mode sequencer: register offsets, fields,
 * reset values and memory offsets.
 * assumes inclusion by the sequencer module and its test bench only.
 */
`ifndef SMMS_DEFS_SVH
`define SMMS_DEFS_SVH

// ==========================================================
// register map (byte addresses)
`define SMMS_OFS_CTRL 8'h00
`define SMMS_OFS_STATUS 8'h04
`define SMMS_OFS_BASE 8'h08
`define SMMS_CTRL_RST 3'h0

// ==========================================================
// management ram layout
`define SMMS_BASE_RST 32'h0003_0000
`define SMMS_HANDLER_OFS 32'h0000_8000
`define SMMS_SAVE_LO 32'h0000_FE00
`define SMMS_SAVE_HI 32'h0000_FFFF
`define SMMS_ALIGN_MASK 32'h0000_7FFF
`define SMMS_SAVE_WORDS 3'h4

// ==========================================================
// control register fields checked on resume
`define SMMS_PAGING_BIT 31
`define SMMS_CACHE_OFF_BIT 30
`define SMMS_NO_WT_BIT 29
`define SMMS_PROTECT_BIT 0
`define SMMS_CTRL_FOUR_RSVD 32'hFFFF_F800

`endif

// *** inc/smms_pkg.sv ***
/*
 * types of the management-mode sequencer.
 * assumes nothing beyond the defs header.
 */
package smms_pkg;
  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_DRAIN = 4'b0001,
    ST_SAVE = 4'b0010,
    ST_ENTER = 4'b0011,
    ST_FETCH = 4'b0100,
    ST_INMODE = 4'b0101,
    ST_RESTORE = 4'b0110,
    ST_CHECK = 4'b0111,
    ST_EXIT = 4'b1000,
    ST_SHUTDN = 4'b1001
  } smms_state_t;

  // ==========================================================
  // software control bits
  typedef struct packed {
    logic variant_txn;
    logic shut_inhibit_en;
    logic align_chk_en;
  } smms_ctrl_t;
endpackage

// *** dv/smms_ram_model.sv ***
/*
 * partner model of the management ram decode: answers save and restore
 *   words one at a time after a selectable delay.
 * assumes the sequencer's request/ack memory port and a base of 30000h.
 */
`timescale 1ns/1ps
module smms_ram_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] delay_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [31:0] mem_wdata_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  logic [31:0] ram [4];
  logic [1:0] wait_cnt;
  logic hit;
  logic go;

  // ==========================================================
  // decode and answer
  // only base plus 8000h up to ffffh is decoded; a miss is never answered
  // redirect by address alone: the save words go out before the entry signal
  assign hit = (mem_addr_i[31:16] == 16'h0003) && mem_addr_i[15];
  assign go = mem_req_i && hit && !mem_ack_o;
  always @(posedge clk_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'b0;
      wait_cnt <= 2'h0;
      mem_rdata_o <= 32'hA5A5_A5A5;
    end else if (go && wait_cnt == delay_i) begin
      mem_ack_o <= 1'b1;
      wait_cnt <= 2'h0;
      if (mem_we_i) begin
        ram[mem_addr_i[3:2]] <= mem_wdata_i;
      end else begin
        mem_rdata_o <= ram[mem_addr_i[3:2]];
      end
    end else begin
      mem_ack_o <= 1'b0;
      if (go) begin
        wait_cnt <= wait_cnt + 2'h1;
      end
      // released data must not look valid
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule

// *** dv/smms_sequencer_test.sv ***
/*
 * self-checking bench of the management-mode sequencer with a ram model.
 * assumes the defs header on the include path.
 */
`timescale 1ns/1ps
`include "smms_defs.svh"
module smms_sequencer_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq_n = 1'b1, hold = 1'b0;
  logic sd = 1'b1, res = 1'b0, nmi = 1'b0, init = 1'b0, bnd = 1'b1, ret = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wd = 32'h0, rdat, rd, czero = 32'h0, cfour = 32'h0;
  logic [31:0] haddr, rzero, rfour, maddr, mwd, mrd;
  logic [1:0] mode = 2'h0, dly = 2'h0, rmode;
  logic drain, blk, fetch, fault, done, sdn, sdc, inh_i, inh_a, act_n, ackt, st4;
  logic mreq, mwe, mack;
  int failures = 0, checks = 0, cycles = 0, ackt_n = 0, sdc_n = 0;
  int seed = 32'hB292_D007;
  logic [31:0] sv_a[$];
  logic [1:0] bad_i[4] = '{2'h1, 2'h0, 2'h0, 2'h3};
  logic [31:0] bad_v[4] = '{32'h0000_0800, 32'h8000_0000, 32'h2000_0001, 32'h0003_4000};

  smms_sequencer smms_sequencer_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rdat), .wb_ack_o(ack), .mgmt_interrupt_n_i(irq_n), .boundary_i(bnd),
    .int_hold_i(hold), .retired_i(ret), .stores_done_i(sd), .resume_from_mgmt_i(res),
    .nmi_i(nmi), .init_i(init), .cur_mode_i(mode), .control_reg_zero_i(czero),
    .control_reg_four_i(cfour), .drain_req_o(drain), .int_block_o(blk),
    .handler_fetch_o(fetch), .handler_addr_o(haddr), .invalid_opcode_fault_o(fault),
    .resume_done_o(done), .restored_mode_o(rmode), .restored_control_reg_zero_o(rzero),
    .restored_control_reg_four_o(rfour), .mem_req_o(mreq), .mem_we_o(mwe), .mem_addr_o(maddr),
    .mem_wdata_o(mwd), .mem_ack_i(mack), .mem_rdata_i(mrd), .mgmt_active_n_o(act_n),
    .mgmt_ack_transaction_o(ackt), .ext_status_four_o(st4), .shutdown_o(sdn),
    .shutdown_cycle_o(sdc), .inhibit_maskable_int_req_o(inh_i),
    .inhibit_addr_bit20_mask_o(inh_a));
  smms_ram_model smms_ram_model_i (.clk_i(clk_i), .rst_i(rst_i), .delay_i(dly),
    .mem_req_i(mreq), .mem_we_i(mwe), .mem_addr_i(maddr), .mem_wdata_i(mwd),
    .mem_ack_o(mack), .mem_rdata_o(mrd));

  // ==========================================================
  // clock, monitors, helpers
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (mreq && mack && mwe) sv_a.push_back(maddr);
    if (ackt) ackt_n++;
    if (sdc) sdc_n++;
    if (cycles > 20000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_for(ref logic s, input logic v, input string nm);
    int n;
    n = 0;
    while (s !== v && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    chk(nm, {31'h0, s}, {31'h0, v});
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk("wb_ack", {31'h0, ack}, 32'h1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic pulse_irq();
    @(posedge clk_i);
    irq_n <= 1'b0;
    @(posedge clk_i);
    irq_n <= 1'b1;
  endtask
  task automatic resume_req();
    @(posedge clk_i);
    mode <= mode ^ 2'h1;
    czero <= czero ^ 32'h0000_0F00;
    cfour <= 32'h0;
    res <= 1'b1;
    @(posedge clk_i);
    res <= 1'b0;
  endtask
  task automatic enter(input logic [1:0] m, input logic [31:0] c0, input logic [31:0] c4,
                       input logic txn);
    sv_a.delete();
    mode <= m;
    czero <= c0;
    cfour <= c4;
    sd <= 1'b0;
    nmi <= 1'b1;
    hold <= 1'b1;
    pulse_irq();
    repeat (4) @(posedge clk_i);
    chk("int_block", {31'h0, blk}, 32'h1);
    chk("drain_held", {31'h0, drain}, 32'h0);
    hold <= 1'b0;
    nmi <= 1'b0;
    wait_for(drain, 1'b1, "drain");
    repeat (3) @(posedge clk_i);
    chk("save_early", {31'h0, mreq}, 32'h0);
    sd <= 1'b1;
    wait_for(fetch, 1'b1, "fetch");
    chk("handler", haddr, `SMMS_BASE_RST + `SMMS_HANDLER_OFS);
    chk("active_n", {31'h0, act_n}, {31'h0, txn});
    chk("status_four", {31'h0, st4}, {31'h0, txn});
    chk("save_words", sv_a.size(), 32'h4);
    foreach (sv_a[i]) chk("save_addr", sv_a[i], `SMMS_BASE_RST + `SMMS_SAVE_LO + 4 * i);
  endtask
  task automatic leave(input logic [1:0] m, input logic [31:0] c0, input logic [31:0] c4);
    resume_req();
    wait_for(done, 1'b1, "resume_done");
    chk("mode", {30'h0, rmode}, {30'h0, m});
    chk("ctrl_zero", rzero, c0);
    chk("ctrl_four", rfour, c4);
    chk("active_n_exit", {31'h0, act_n}, 32'h1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [1:0] m;
    logic [31:0] c0, c4;
    int a0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, `SMMS_OFS_BASE, 32'h0001_0000);
    wb(1'b0, `SMMS_OFS_BASE, 32'h0);
    chk("base", rd, `SMMS_BASE_RST);
    wb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", rd, 32'h0);
    resume_req();
    @(posedge clk_i);
    chk("fault", {31'h0, fault}, 32'h1);
    chk("no_entry", {31'h0, act_n}, 32'h1);
    $display("test reset and stray resume done");
    for (int k = 0; k < 12; k++) begin
      m = 2'({$random(seed)} % 3);
      c0 = $random(seed) & 32'h5FFF_FFFF;
      c4 = $random(seed) & ~`SMMS_CTRL_FOUR_RSVD;
      dly <= 2'($random(seed));
      wb(1'b1, `SMMS_OFS_CTRL, {29'h0, k[0], 2'h0});
      a0 = ackt_n;
      enter(m, c0, c4, k[0]);
      if (k == 3) begin
        pulse_irq();
        pulse_irq();
        wb(1'b0, `SMMS_OFS_STATUS, 32'h0);
        chk("pending", {30'h0, rd[1:0]}, 32'h3);
        leave(m, c0, c4);
        wait_for(fetch, 1'b1, "refetch");
        m = m ^ 2'h1;
        c0 = c0 ^ 32'h0000_0F00;
        c4 = 32'h0;
      end
      leave(m, c0, c4);
      chk("status_four_exit", {31'h0, st4}, 32'h0);
      // let the monitor count the exit pulse first
      @(posedge clk_i);
      chk("ack_txn", ackt_n - a0, k[0] && k != 3 ? 32'h2 : k[0] ? 32'h4 : 32'h0);
      wb(1'b0, `SMMS_OFS_STATUS, 32'h0);
      chk("status_idle", {29'h0, rd[2:0]}, 32'h0);
    end
    $display("test entry and resume done");
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, `SMMS_OFS_CTRL, k == 3 ? 32'h3 : 32'h2);
      enter(2'h1, 32'h11, 32'h0, 1'b0);
      smms_ram_model_i.ram[bad_i[k]] = bad_v[k];
      a0 = sdc_n;
      resume_req();
      wait_for(sdn, 1'b1, "shutdown");
      @(posedge clk_i);
      chk("shutdown_cycle", sdc_n - a0, 32'h1);
      chk("inhibits", {30'h0, inh_i, inh_a}, 32'h3);
      // a management request is not used to leave shutdown
      pulse_irq();
      chk("still_down", {31'h0, sdn}, 32'h1);
      if (k[0]) init <= 1'b1;
      else nmi <= 1'b1;
      wait_for(sdn, 1'b0, "wake");
      init <= 1'b0;
      nmi <= 1'b0;
      @(posedge clk_i);
    end
    $display("test shutdown done");
    conclude();
  end
endmodule
